// file: tone_mixer_eq_control_regs.sv
// register bank for mixer, shelving tone, eq enables and freeze
`timescale 1ns/100ps
// Summary of operation
// - right field: 00 right, 01/10 average, 11 left feeds channel B
// - left field: 00 left, 01/10 average, 11 right feeds channel A
// - de-emphasis bit 1 inserts 44.1 kHz 50/15 us filter, 0 none
// - loudness compensation active only while its bit is 1, reset 0
// - path high-pass bypassed at 0 (reset), applied at 1
// - high-shelf corner 5/7/10/15 kHz for codes 00..11, reset 00
// - low-shelf corner 50/100/200/250 Hz, reset 01
// - one enable turns both shelving filters on, reset 0
// - high-shelf gain 1.5 dB steps, 0000 +12, 1000 0 dB, reset 1000
// - low-shelf gain same mapping, reset 1000
// - freeze holds volume and coefficient effect, release applies all together
// - 07h: preemphasis_undo_enable, loudness, hpf, high corner 4:3, low corner 2:1, enable 0
// - 08h: high-shelf gain 7:4, low-shelf gain 3:0
// - 09h: freeze, tristate, crossover 5:3, reserved 2, eq B, eq A
// - crossover 000 disables manager, 001..111 select 80..320 Hz
// - each channel eq enable turns its biquad bank on, default off
// - 06h: right field 3:2, left field 1:0, bit 4 reserved
module tone_mixer_eq_control_regs
  import tone_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [2:0] input_attenuation,
  output tone_regs_pkg::blend_t right_blend_select,
  output tone_regs_pkg::blend_t left_blend_select,
  output logic chan_a_avg,
  output logic chan_a_from_right,
  output logic chan_b_avg,
  output logic chan_b_from_left,
  output logic preemphasis_undo_enable,
  output logic loudness_enable,
  output logic path_highpass_enable,
  output logic [1:0] high_shelf_corner,
  output logic [1:0] low_shelf_corner,
  output logic shelving_filter_enable,
  output logic [3:0] high_shelf_gain,
  output logic [3:0] low_shelf_gain,
  output logic freeze,
  output logic logic_output_tristate,
  output logic [2:0] crossover_manager_select,
  output logic bass_manager_enable,
  output logic chan_b_biquad_enable,
  output logic chan_a_biquad_enable,
  output logic update_hold,
  output logic update_apply
);
  import tone_regs_pkg::*;

  logic [7:0] blend_q;
  logic [7:0] shelf_cfg_q;
  logic [7:0] shelf_gain_q;
  logic [7:0] eq_ctrl_q;
  logic freeze_prev_q;
  logic [7:0] rdata_q;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // reserved bits are masked so they never store
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      blend_q <= RST_BLEND;
      shelf_cfg_q <= RST_SHELF_CFG;
      shelf_gain_q <= RST_SHELF_GAIN;
      eq_ctrl_q <= RST_EQ_CTRL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_BLEND)
        blend_q <= reg_wdata & MASK_BLEND;
      else if (reg_addr == ADDR_SHELF_CFG)
        shelf_cfg_q <= reg_wdata;
      else if (reg_addr == ADDR_SHELF_GAIN)
        shelf_gain_q <= reg_wdata;
      else if (reg_addr == ADDR_EQ_CTRL)
        eq_ctrl_q <= reg_wdata & MASK_EQ_CTRL;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // unmapped addresses read zero; data registered for a clean output
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_BLEND)
        rdata_q <= blend_q;
      else if (reg_addr == ADDR_SHELF_CFG)
        rdata_q <= shelf_cfg_q;
      else if (reg_addr == ADDR_SHELF_GAIN)
        rdata_q <= shelf_gain_q;
      else if (reg_addr == ADDR_EQ_CTRL)
        rdata_q <= eq_ctrl_q;
      else
        rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // freeze release detect
  // ----------------------------------------
  // one-cycle pulse on the falling freeze bit commits all held values at once
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      freeze_prev_q <= 1'b0;
    else
      freeze_prev_q <= eq_ctrl_q[BIT_FREEZE];
  end
  assign freeze = eq_ctrl_q[BIT_FREEZE];
  assign update_hold = eq_ctrl_q[BIT_FREEZE];
  assign update_apply = freeze_prev_q & ~eq_ctrl_q[BIT_FREEZE];

  // ----------------------------------------
  // control fields to the audio path
  // ----------------------------------------
  assign input_attenuation = blend_q[7:5];
  assign right_blend_select = blend_t'(blend_q[3:2]);
  assign left_blend_select = blend_t'(blend_q[1:0]);
  // both middle codes average; the path only needs these decoded strobes
  assign chan_b_avg = (blend_q[3:2] == BLEND_AVG1) | (blend_q[3:2] == BLEND_AVG2);
  assign chan_b_from_left = (blend_q[3:2] == BLEND_SWAP);
  assign chan_a_avg = (blend_q[1:0] == BLEND_AVG1) | (blend_q[1:0] == BLEND_AVG2);
  assign chan_a_from_right = (blend_q[1:0] == BLEND_SWAP);
  assign preemphasis_undo_enable = shelf_cfg_q[BIT_PREEMPH_UNDO];
  assign loudness_enable = shelf_cfg_q[BIT_LOUD];
  assign path_highpass_enable = shelf_cfg_q[BIT_HPF];
  assign high_shelf_corner = shelf_cfg_q[4:3];
  assign low_shelf_corner = shelf_cfg_q[2:1];
  assign shelving_filter_enable = shelf_cfg_q[BIT_SHELF_EN];
  assign high_shelf_gain = shelf_gain_q[7:4];
  assign low_shelf_gain = shelf_gain_q[3:0];
  assign logic_output_tristate = eq_ctrl_q[BIT_TRISTATE];
  assign crossover_manager_select = eq_ctrl_q[5:3];
  assign bass_manager_enable = (eq_ctrl_q[5:3] != XOVER_OFF);
  assign chan_b_biquad_enable = eq_ctrl_q[BIT_EQ_B];
  assign chan_a_biquad_enable = eq_ctrl_q[BIT_EQ_A];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_reset_values;
    @(posedge clk_sys) $past(reset) |-> (high_shelf_gain == 4'h8 && low_shelf_gain == 4'h8
      && low_shelf_corner == 2'b01 && high_shelf_corner == 2'b00 && !shelving_filter_enable);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (reset) (blend_q[4] == 1'b0) && (eq_ctrl_q[2] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_gain_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_GAIN)
      |=> (high_shelf_gain == $past(reg_wdata[7:4]) && low_shelf_gain == $past(reg_wdata[3:0]));
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write lost");

  property p_cfg_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_CFG)
      |=> (preemphasis_undo_enable == $past(reg_wdata[7]) && low_shelf_corner == $past(reg_wdata[2:1]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_freeze_apply;
    @(posedge clk_sys) disable iff (reset) (freeze ##1 !freeze) |-> update_apply ##1 !update_apply;
  endproperty
  a_freeze_apply: assert property (p_freeze_apply) else $error("freeze release not applied");

  property p_mix_b;
    @(posedge clk_sys) disable iff (reset) chan_b_from_left |-> (blend_q[3:2] == 2'b11 && !chan_b_avg);
  endproperty
  a_mix_b: assert property (p_mix_b) else $error("channel B source wrong");

  property p_mix_a;
    @(posedge clk_sys) disable iff (reset) (blend_q[1:0] == 2'b00) |-> (!chan_a_avg && !chan_a_from_right);
  endproperty
  a_mix_a: assert property (p_mix_a) else $error("channel A source wrong");

  property p_xover;
    @(posedge clk_sys) disable iff (reset)
      (reg_wr && reg_addr == ADDR_EQ_CTRL && reg_wdata[5:3] == 3'h0) |=> !bass_manager_enable;
  endproperty
  a_xover: assert property (p_xover) else $error("bass manager not disabled");

  property p_eq_hold;
    @(posedge clk_sys) disable iff (reset)
      !(reg_wr && reg_addr == ADDR_EQ_CTRL) |=> $stable(chan_a_biquad_enable) && $stable(chan_b_biquad_enable);
  endproperty
  a_eq_hold: assert property (p_eq_hold) else $error("eq enable changed unbidden");

  // ----------------------------------------
  // field, read path and release checks
  // ----------------------------------------
  // each field except the 06h attenuation bits 7:5 is checked against the bus data of the write edge,
  // so a swapped or shifted slice shows up on the first write
  property p_mix_b_right;
    @(posedge clk_sys) disable iff (reset) (blend_q[3:2] == 2'b00) |-> (!chan_b_avg && !chan_b_from_left);
  endproperty
  a_mix_b_right: assert property (p_mix_b_right) else $error("channel B direct source wrong");

  property p_mix_b_avg;
    @(posedge clk_sys) disable iff (reset) (blend_q[3:2] == 2'b01 || blend_q[3:2] == 2'b10) |-> chan_b_avg;
  endproperty
  a_mix_b_avg: assert property (p_mix_b_avg) else $error("channel B average missing");

  property p_mix_a_avg;
    @(posedge clk_sys) disable iff (reset) (blend_q[1:0] == 2'b01 || blend_q[1:0] == 2'b10) |-> chan_a_avg;
  endproperty
  a_mix_a_avg: assert property (p_mix_a_avg) else $error("channel A average missing");

  property p_mix_a_swap;
    @(posedge clk_sys) disable iff (reset) (blend_q[1:0] == 2'b11) |-> (!chan_a_avg && chan_a_from_right);
  endproperty
  a_mix_a_swap: assert property (p_mix_a_swap) else $error("channel A swap source wrong");

  property p_blend_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_BLEND) |=> (blend_q[3:0] == $past(reg_wdata[3:0]));
  endproperty
  a_blend_write: assert property (p_blend_write) else $error("mixer write lost");

  property p_blend_reserved;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_BLEND && reg_wdata[4]) |=> !blend_q[4];
  endproperty
  a_blend_reserved: assert property (p_blend_reserved) else $error("mixer reserved bit stored");

  property p_loud_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_CFG) |=> loudness_enable == $past(reg_wdata[6]);
  endproperty
  a_loud_write: assert property (p_loud_write) else $error("loudness write lost");

  property p_hpf_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_CFG) |=> path_highpass_enable == $past(reg_wdata[5]);
  endproperty
  a_hpf_write: assert property (p_hpf_write) else $error("high-pass write lost");

  property p_high_corner_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_CFG) |=> high_shelf_corner == $past(reg_wdata[4:3]);
  endproperty
  a_high_corner_write: assert property (p_high_corner_write) else $error("high corner write lost");

  property p_shelf_en_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_SHELF_CFG) |=> shelving_filter_enable == $past(reg_wdata[0]);
  endproperty
  a_shelf_en_write: assert property (p_shelf_en_write) else $error("shelving enable write lost");

  property p_cfg_hold;
    @(posedge clk_sys) disable iff (reset) !(reg_wr && reg_addr == ADDR_SHELF_CFG) |=> $stable(shelf_cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unbidden");

  property p_gain_hold;
    @(posedge clk_sys) disable iff (reset) !(reg_wr && reg_addr == ADDR_SHELF_GAIN) |=> $stable(shelf_gain_q);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed unbidden");

  property p_blend_hold;
    @(posedge clk_sys) disable iff (reset) !(reg_wr && reg_addr == ADDR_BLEND) |=> $stable(blend_q);
  endproperty
  a_blend_hold: assert property (p_blend_hold) else $error("mixer changed unbidden");

  property p_eq_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_EQ_CTRL)
      |=> (freeze == $past(reg_wdata[7]) && logic_output_tristate == $past(reg_wdata[6])
      && crossover_manager_select == $past(reg_wdata[5:3]));
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("eq control write lost");

  property p_eq_reserved;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_EQ_CTRL && reg_wdata[2]) |=> !eq_ctrl_q[2];
  endproperty
  a_eq_reserved: assert property (p_eq_reserved) else $error("eq reserved bit stored");

  property p_xover_on;
    @(posedge clk_sys) disable iff (reset) (crossover_manager_select != 3'h0) |-> bass_manager_enable;
  endproperty
  a_xover_on: assert property (p_xover_on) else $error("bass manager not enabled");

  property p_biquad_write;
    @(posedge clk_sys) disable iff (reset) (reg_wr && reg_addr == ADDR_EQ_CTRL)
      |=> (chan_a_biquad_enable == $past(reg_wdata[0]) && chan_b_biquad_enable == $past(reg_wdata[1]));
  endproperty
  a_biquad_write: assert property (p_biquad_write) else $error("biquad enable write lost");

  // an apply pulse outside a release would commit half-written values
  property p_apply_cause;
    @(posedge clk_sys) disable iff (reset) update_apply |-> ($past(freeze) && !freeze);
  endproperty
  a_apply_cause: assert property (p_apply_cause) else $error("apply without release");

  property p_no_apply_held;
    @(posedge clk_sys) disable iff (reset) freeze |-> (update_hold && !update_apply);
  endproperty
  a_no_apply_held: assert property (p_no_apply_held) else $error("apply while frozen");

  property p_apply_single;
    @(posedge clk_sys) disable iff (reset) update_apply |=> !update_apply;
  endproperty
  a_apply_single: assert property (p_apply_single) else $error("apply longer than one cycle");

  property p_read_cfg;
    @(posedge clk_sys) disable iff (reset) (reg_rd && reg_addr == ADDR_SHELF_CFG) |=> reg_rdata == $past(shelf_cfg_q);
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("config read wrong");

  property p_read_gain;
    @(posedge clk_sys) disable iff (reset) (reg_rd && reg_addr == ADDR_SHELF_GAIN) |=> reg_rdata == $past(shelf_gain_q);
  endproperty
  a_read_gain: assert property (p_read_gain) else $error("gain read wrong");

  property p_read_eq;
    @(posedge clk_sys) disable iff (reset) (reg_rd && reg_addr == ADDR_EQ_CTRL) |=> reg_rdata == $past(eq_ctrl_q);
  endproperty
  a_read_eq: assert property (p_read_eq) else $error("eq control read wrong");

  property p_read_blend;
    @(posedge clk_sys) disable iff (reset) (reg_rd && reg_addr == ADDR_BLEND) |=> reg_rdata == $past(blend_q);
  endproperty
  a_read_blend: assert property (p_read_blend) else $error("mixer read wrong");

  property p_read_unmapped;
    @(posedge clk_sys) disable iff (reset) (reg_rd && (reg_addr < ADDR_BLEND || reg_addr > ADDR_EQ_CTRL))
      |=> reg_rdata == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_reset_enables;
    @(posedge clk_sys) $past(reset) |-> (!preemphasis_undo_enable && !loudness_enable && !path_highpass_enable
      && !chan_a_biquad_enable && !chan_b_biquad_enable && !freeze && !update_apply);
  endproperty
  a_reset_enables: assert property (p_reset_enables) else $error("enable not off after reset");

  property p_reset_low;
    @(posedge clk_sys) $past(reset) |-> (low_shelf_gain == 4'h8 && low_shelf_corner == 2'b01);
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("low shelf reset wrong");
endmodule

// file: tone_regs_pkg.sv
// constants for the tone, mixer and eq control register bank
package tone_regs_pkg;
  localparam logic [7:0] ADDR_BLEND = 8'h06;
  localparam logic [7:0] ADDR_SHELF_CFG = 8'h07;
  localparam logic [7:0] ADDR_SHELF_GAIN = 8'h08;
  localparam logic [7:0] ADDR_EQ_CTRL = 8'h09;
  localparam logic [7:0] ADDR_COEF_LO = 8'h0A;
  localparam logic [7:0] ADDR_COEF_HI = 8'h54;
  localparam logic [7:0] ADDR_VOL_LO = 8'h57;
  localparam logic [7:0] ADDR_VOL_HI = 8'h5A;
  localparam logic [7:0] RST_BLEND = 8'h00;
  localparam logic [7:0] RST_SHELF_CFG = 8'h02;
  localparam logic [7:0] RST_SHELF_GAIN = 8'h88;
  localparam logic [7:0] RST_EQ_CTRL = 8'h00;
  localparam logic [7:0] MASK_BLEND = 8'hEF;
  localparam logic [7:0] MASK_EQ_CTRL = 8'hFB;
  localparam int BIT_PREEMPH_UNDO = 7;
  localparam int BIT_LOUD = 6;
  localparam int BIT_HPF = 5;
  localparam int BIT_SHELF_EN = 0;
  localparam int BIT_FREEZE = 7;
  localparam int BIT_TRISTATE = 6;
  localparam int BIT_EQ_B = 1;
  localparam int BIT_EQ_A = 0;
  localparam logic [2:0] XOVER_OFF = 3'h0;
  typedef enum logic [1:0] {
    BLEND_DIRECT = 2'b00,
    BLEND_AVG1 = 2'b01,
    BLEND_AVG2 = 2'b10,
    BLEND_SWAP = 2'b11
  } blend_t;
endpackage

// file: tone_host.sv
// host model driving the register port of the tone control bank
`timescale 1ns/100ps
module tone_host
(
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // after a write, address and data show the inverse of their last value; a read inverts only the address
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
  end
  // one write, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read data is registered late, so take it one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

// file: tb_tone_mixer_eq_control_regs.sv
// testbench for the tone, mixer and eq control register bank
`timescale 1ns/100ps
module tb_tone_mixer_eq_control_regs;
  import tone_regs_pkg::*;
  logic clk_sys, reset, reg_wr, reg_rd, a_avg, a_fr, b_avg, b_fl, deem, loud, hpf, shen, frz, tri_s, bm_en;
  logic eqb, eqa, hold, apply;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] hg, lg;
  logic [2:0] att, xo;
  logic [1:0] hc, lc;
  blend_t rsel, lsel;
  int failures = 0;
  int checks = 0;
  tone_host tone_host_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  tone_mixer_eq_control_regs tone_mixer_eq_control_regs_i (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .input_attenuation(att),
    .right_blend_select(rsel), .left_blend_select(lsel), .chan_a_avg(a_avg), .chan_a_from_right(a_fr),
    .chan_b_avg(b_avg), .chan_b_from_left(b_fl), .preemphasis_undo_enable(deem), .loudness_enable(loud),
    .path_highpass_enable(hpf), .high_shelf_corner(hc), .low_shelf_corner(lc), .shelving_filter_enable(shen),
    .high_shelf_gain(hg), .low_shelf_gain(lg), .freeze(frz), .logic_output_tristate(tri_s),
    .crossover_manager_select(xo), .bass_manager_enable(bm_en), .chan_b_biquad_enable(eqb),
    .chan_a_biquad_enable(eqa), .update_hold(hold), .update_apply(apply));
  // ----------------------------------------
  // clock and shared checks
  // ----------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] e [4] = '{8'h00, 8'h02, 8'h88, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      tone_host_i.rd(8'h06 + i[7:0], d);
      chk("reset readback", e[i], d);
    end
  endtask
  // every mixer code on both fields, reserved bit 4 written as one
  task automatic t_blend();
    logic [7:0] d;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      tone_host_i.wr(ADDR_BLEND, {3'h5, 1'b1, c, ~c});
      chk("mixer decode", {4'h0, c == 2'h1 || c == 2'h2, c == 2'h3, c == 2'h1 || c == 2'h2, c == 2'h0}, {4'h0, b_avg, b_fl, a_avg, a_fr});
      chk("mixer fields", {3'h5, 1'b0, c, ~c}, {att, 1'b0, rsel, lsel});
      tone_host_i.rd(ADDR_BLEND, d);
      chk("mixer readback", {3'h5, 1'b0, c, ~c}, d);
    end
  endtask
  // alternating patterns catch swapped or shifted fields
  task automatic t_shelf();
    logic [7:0] v [2] = '{8'hA5, 8'h5A};
    for (int i = 0; i < 2; i++)
    begin
      tone_host_i.wr(ADDR_SHELF_CFG, v[i]);
      chk("shelf config", v[i], {deem, loud, hpf, hc, lc, shen});
      tone_host_i.wr(ADDR_SHELF_GAIN, ~v[i]);
      chk("shelf gains", ~v[i], {hg, lg});
    end
  endtask
  task automatic t_eq();
    logic [7:0] d;
    for (int x = 0; x < 8; x++)
    begin
      tone_host_i.wr(ADDR_EQ_CTRL, {2'b01, x[2:0], 1'b1, x[0], ~x[0]});
      chk("eq control", {2'b01, x[2:0], x != 0, x[0], ~x[0]}, {frz, tri_s, xo, bm_en, eqb, eqa});
      tone_host_i.rd(ADDR_EQ_CTRL, d);
      chk("eq readback", {2'b01, x[2:0], 1'b0, x[0], ~x[0]}, d);
    end
  endtask
  // freeze, a volume write elsewhere, then release with one apply pulse
  task automatic t_freeze();
    logic [7:0] d;
    tone_host_i.wr(ADDR_EQ_CTRL, 8'h80);
    chk("hold on freeze", 8'h02, {6'h0, hold, apply});
    tone_host_i.wr(ADDR_VOL_LO + 8'h01, 8'h33);
    tone_host_i.rd(ADDR_VOL_LO + 8'h01, d);
    chk("unmapped read", 8'h00, d);
    tone_host_i.rd(ADDR_EQ_CTRL, d);
    chk("freeze kept", 8'h80, d);
    tone_host_i.wr(ADDR_EQ_CTRL, 8'h00);
    chk("apply on release", 8'h01, {frz, 5'h0, hold, apply});
    @(negedge clk_sys);
    chk("apply one cycle", 8'h00, {7'h0, apply});
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    t_reset();
    t_blend();
    t_shelf();
    t_eq();
    t_freeze();
    conclude();
  end
  // a hung run counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    conclude();
  end
endmodule
